// file: rtl/sdcad_pkg.sv
package sdcad_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MR_BASE = 8'h20;
    localparam logic [7:0] REG_MR_LAST = 8'h3c;

    localparam logic [1:0] WIDTH_X4 = 2'h0;
    localparam logic [1:0] WIDTH_X8 = 2'h1;
    localparam logic [1:0] WIDTH_X16 = 2'h2;
    localparam logic [1:0] CFG_RESET = 2'h1;

    localparam int STAT_OPEN_LSB = 0;
    localparam int STAT_CRC_ERR_BIT = 16;
    localparam int STAT_CMD_LSB = 17;
    localparam int STAT_BUSY_BIT = 20;

    // ----------------------------------------
    // Mode register and command address bit positions
    // ----------------------------------------
    localparam int MODE_ONE_TERM_BIT = 11;
    localparam int MODE_TWO_CRC_BIT = 12;
    localparam int MODE_FOUR_VREF_BIT = 4;
    localparam int MODE_FIVE_MASK_BIT = 10;
    localparam int MODE_FIVE_WINV_BIT = 11;
    localparam int MODE_FIVE_RINV_BIT = 12;
    localparam int AUTO_PRECH_BIT = 10;
    localparam int CHOP_BIT = 12;
    localparam logic [13:0] MR_RESET = 14'h0000;

    // ----------------------------------------
    // Burst, CRC and test constants
    // ----------------------------------------
    localparam logic [3:0] BURST_FULL = 4'h8;
    localparam logic [3:0] BURST_CHOP = 4'h4;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam int INV_ZERO_LIMIT = 4;
    localparam logic VREF_TEST_LEVEL = 1'b1;

    typedef enum logic [2:0] {
        CMD_MODE_SET = 3'b000,
        CMD_REF = 3'b001,
        CMD_PRE = 3'b010,
        CMD_RFU = 3'b011,
        CMD_WR = 3'b100,
        CMD_RD = 3'b101,
        CMD_ZQ = 3'b110,
        CMD_NOP = 3'b111
    } sdcad_cmd_t;

    typedef enum logic [2:0] {
        DP_IDLE = 3'b000,
        DP_WRITE = 3'b001,
        DP_WCRC = 3'b010,
        DP_READ = 3'b011,
        DP_RCRC = 3'b100
    } sdcad_state_t;

endpackage

// file: rtl/sdcad_top.sv
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps

module sdcad_top
    import sdcad_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    input wire logic I_DEV_RESET_LOW,
    input wire logic I_CHIP_SELECT_LOW,
    input wire logic I_ACTIVATE_STROBE_LOW,
    input wire logic I_ROW_STROBE,
    input wire logic I_COLUMN_STROBE,
    input wire logic I_WRITE_ENABLE,
    input wire logic [1:0] I_BANK_GROUP_SELECT,
    input wire logic [1:0] I_BANK_SELECT,
    input wire logic [13:0] I_ADDR,
    input wire logic I_ADDR17,
    input wire logic [7:0] I_DQ,
    output logic [7:0] O_DQ,
    output logic [7:0] O_DQ_OE_LOW,
    input wire logic I_DQS_T,
    input wire logic I_DQS_C,
    output logic O_DQS_T,
    output logic O_DQS_C,
    output logic O_DQS_OE_LOW,
    input wire logic I_WRITE_MASK_LOW,
    output logic O_BUS_INVERSION_LOW,
    output logic O_MASK_PIN_OE_LOW,
    output logic O_TERMINATION_STROBE_EN,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [34:0] pin_s1;
    logic [34:0] pin_s2;
    logic dev_rst_s1;
    logic dev_rst_s2;
    logic rst;

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            dev_rst_s1 <= 1'b0;
            dev_rst_s2 <= 1'b0;
        end else if (I_CE) begin
            dev_rst_s1 <= I_DEV_RESET_LOW;
            dev_rst_s2 <= dev_rst_s1;
        end
    end

    // Pin low keeps everything below in reset except the pin_s1/pin_s2 syncs and the bank_row and mem arrays
    assign rst = I_RESET | ~dev_rst_s2;

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else if (I_CE) begin
            pin_s1 <= {I_CHIP_SELECT_LOW, I_ACTIVATE_STROBE_LOW, I_ROW_STROBE, I_COLUMN_STROBE,
                       I_WRITE_ENABLE, I_BANK_GROUP_SELECT, I_BANK_SELECT, I_ADDR17, I_ADDR,
                       I_DQS_T, I_DQS_C, I_DQ, I_WRITE_MASK_LOW};
            pin_s2 <= pin_s1;
        end
    end

    logic cs_low;
    logic act_low;
    logic [2:0] cmd_pins;
    logic [1:0] bg_pin;
    logic [1:0] ba;
    logic a17_pin;
    logic [13:0] addr;
    logic dqs_t;
    logic dqs_c;
    logic [7:0] dq_in;
    logic mask_pin;

    assign cs_low = pin_s2[34];
    assign act_low = pin_s2[33];
    assign cmd_pins = pin_s2[32:30];
    assign bg_pin = pin_s2[29:28];
    assign ba = pin_s2[27:26];
    assign a17_pin = pin_s2[25];
    assign addr = pin_s2[24:11];
    assign dqs_t = pin_s2[10];
    assign dqs_c = pin_s2[9];
    assign dq_in = pin_s2[8:1];
    assign mask_pin = pin_s2[0];

    // ----------------------------------------
    // Configuration and mode registers
    // ----------------------------------------
    logic [1:0] width;
    logic [13:0] mr [0:7];
    logic [1:0] bg;
    logic a17;
    logic term_fn;
    logic mask_fn;
    logic wdbi_fn;
    logic rdbi_fn;
    logic crc_en;

    assign bg = (width == WIDTH_X16) ? {1'b0, bg_pin[0]} : bg_pin;
    assign a17 = (width == WIDTH_X4) ? a17_pin : 1'b0;
    assign term_fn = (width == WIDTH_X8) && mr[1][MODE_ONE_TERM_BIT];
    assign mask_fn = mr[5][MODE_FIVE_MASK_BIT] && !term_fn;
    assign wdbi_fn = mr[5][MODE_FIVE_WINV_BIT] && !term_fn;
    assign rdbi_fn = mr[5][MODE_FIVE_RINV_BIT] && !term_fn;
    assign crc_en = mr[2][MODE_TWO_CRC_BIT];

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    logic cmd_valid;
    logic is_act;
    logic is_cmd;
    sdcad_cmd_t cmd;
    logic [3:0] bank_idx;
    logic [17:0] row;

    // Sampled on the rising edge only; I_CLK stands for the true clock
    assign cmd_valid = I_CE && !cs_low;
    assign is_act = cmd_valid && !act_low;
    assign is_cmd = cmd_valid && act_low;
    assign cmd = sdcad_cmd_t'(cmd_pins);
    assign bank_idx = {bg, ba};
    assign row = {a17, cmd_pins, addr};

    always_ff @(posedge I_CLK) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                mr[i] <= MR_RESET;
            end
        end else if (is_cmd && cmd == CMD_MODE_SET) begin
            mr[{bg[0], ba}] <= addr;
        end
    end

    // ----------------------------------------
    // Bank state
    // ----------------------------------------
    logic [15:0] bank_open;
    logic [17:0] bank_row [0:15];
    logic burst_done;
    logic cur_ap;
    logic [3:0] cur_bank;

    always_ff @(posedge I_CLK) begin
        if (rst) begin
            bank_open <= '0;
        end else if (I_CE) begin
            if (burst_done && cur_ap) begin
                bank_open[cur_bank] <= 1'b0;
            end
            if (is_act) begin
                bank_open[bank_idx] <= 1'b1;
            end else if (is_cmd && cmd == CMD_PRE) begin
                if (addr[AUTO_PRECH_BIT]) begin
                    bank_open <= '0;
                end else begin
                    bank_open[bank_idx] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (is_act) begin
            bank_row[bank_idx] <= row;
        end
    end

    // ----------------------------------------
    // Data path
    // ----------------------------------------
    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic int zeros(input logic [7:0] d);
        int n;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            n = n + (d[i] ? 0 : 1);
        end
        return n;
    endfunction

    sdcad_state_t state;
    logic [3:0] beats_left;
    logic [3:0] col;
    logic [7:0] crc;
    logic dqs_prev;
    logic strobe_edge;
    logic [7:0] mem [0:255];
    logic mem_we;
    logic [7:0] wr_data;
    logic [7:0] rd_raw;
    logic rd_inv;
    logic [7:0] rd_beat;
    logic start_rd;
    logic start_wr;
    logic crc_err;
    logic crc_err_set;
    logic crc_err_clr;
    logic [2:0] last_cmd;

    // Only a true differential transition counts; equal legs are noise
    assign strobe_edge = (dqs_t != dqs_c) && (dqs_t != dqs_prev);
    // In x16 mode this lane is the lower byte, timed by the lower byte strobe
    assign start_rd = is_cmd && cmd == CMD_RD && state == DP_IDLE && bank_open[bank_idx];
    assign start_wr = is_cmd && cmd == CMD_WR && state == DP_IDLE && bank_open[bank_idx];
    assign wr_data = (wdbi_fn && !mask_pin) ? ~dq_in : dq_in;
    assign mem_we = I_CE && state == DP_WRITE && strobe_edge && !(mask_fn && !mask_pin);
    assign rd_raw = mem[{cur_bank, col}];
    assign rd_inv = rdbi_fn && (zeros(rd_raw) > INV_ZERO_LIMIT);
    assign rd_beat = rd_inv ? ~rd_raw : rd_raw;
    assign burst_done = (state == DP_WRITE && strobe_edge && beats_left == 4'h1 && !crc_en)
                     || (state == DP_WCRC && strobe_edge)
                     || (state == DP_READ && beats_left == 4'h1 && !crc_en)
                     || (state == DP_RCRC);
    assign crc_err_set = I_CE && state == DP_WCRC && strobe_edge && dq_in != crc;

    always_ff @(posedge I_CLK) begin
        if (mem_we) begin
            mem[{cur_bank, col}] <= wr_data;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (rst) begin
            dqs_prev <= 1'b0;
        end else if (I_CE) begin
            dqs_prev <= dqs_t;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (rst) begin
            state <= DP_IDLE;
            beats_left <= 4'h0;
            col <= 4'h0;
            crc <= CRC_INIT;
            cur_bank <= 4'h0;
            cur_ap <= 1'b0;
        end else if (I_CE) begin
            unique case (state)
                DP_IDLE: begin
                    if (start_rd || start_wr) begin
                        state <= start_rd ? DP_READ : DP_WRITE;
                        beats_left <= addr[CHOP_BIT] ? BURST_FULL : BURST_CHOP;
                        col <= addr[3:0];
                        cur_bank <= bank_idx;
                        cur_ap <= addr[AUTO_PRECH_BIT];
                        crc <= CRC_INIT;
                    end
                end
                DP_WRITE: begin
                    if (strobe_edge) begin
                        col <= col + 4'h1;
                        beats_left <= beats_left - 4'h1;
                        crc <= crc8(crc, dq_in);
                        if (beats_left == 4'h1) begin
                            state <= crc_en ? DP_WCRC : DP_IDLE;
                        end
                    end
                end
                DP_WCRC: begin
                    if (strobe_edge) begin
                        state <= DP_IDLE;
                    end
                end
                DP_READ: begin
                    col <= col + 4'h1;
                    beats_left <= beats_left - 4'h1;
                    crc <= crc8(crc, rd_beat);
                    if (beats_left == 4'h1) begin
                        state <= crc_en ? DP_RCRC : DP_IDLE;
                    end
                end
                DP_RCRC: begin
                    state <= DP_IDLE;
                end
                default: begin
                    state <= DP_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    always_ff @(posedge I_CLK) begin
        if (rst) begin
            O_DQ <= 8'h00;
            O_DQ_OE_LOW <= 8'hff;
            O_DQS_T <= 1'b0;
            O_DQS_OE_LOW <= 1'b1;
            O_BUS_INVERSION_LOW <= 1'b1;
            O_MASK_PIN_OE_LOW <= 1'b1;
        end else if (I_CE) begin
            O_DQ_OE_LOW <= 8'hff;
            O_DQS_OE_LOW <= 1'b1;
            O_MASK_PIN_OE_LOW <= 1'b1;
            O_BUS_INVERSION_LOW <= 1'b1;
            if (state == DP_READ) begin
                // Strobe flips in the same cycle as the data: edge aligned
                O_DQ <= rd_beat;
                O_DQS_T <= ~O_DQS_T;
                O_DQ_OE_LOW <= 8'h00;
                O_DQS_OE_LOW <= 1'b0;
                O_BUS_INVERSION_LOW <= ~rd_inv;
                O_MASK_PIN_OE_LOW <= ~rdbi_fn;
            end else if (state == DP_RCRC) begin
                O_DQ <= crc;
                O_DQS_T <= ~O_DQS_T;
                O_DQ_OE_LOW <= 8'h00;
                O_DQS_OE_LOW <= 1'b0;
            end else if (state == DP_IDLE && mr[4][MODE_FOUR_VREF_BIT]) begin
                O_DQ <= {7'h00, VREF_TEST_LEVEL};
                O_DQ_OE_LOW <= 8'hfe;
            end
        end
    end

    assign O_DQS_C = ~O_DQS_T;
    assign O_TERMINATION_STROBE_EN = term_fn;

    // ----------------------------------------
    // Avalon-MM slave
    // ----------------------------------------
    logic ack;
    logic req;

    assign req = I_AVS_READ || I_AVS_WRITE;
    // Freeze by clock enable must not let a stale ack finish a new request
    assign O_AVS_WAITREQUEST = req && !(ack && I_CE);
    assign crc_err_clr = ack && I_CE && I_AVS_WRITE && I_AVS_ADDRESS == REG_STATUS
                      && I_AVS_BYTEENABLE[2] && I_AVS_WRITEDATA[STAT_CRC_ERR_BIT];

    always_ff @(posedge I_CLK) begin
        if (rst) begin
            ack <= 1'b0;
            width <= CFG_RESET;
            O_AVS_READDATA <= 32'h0000_0000;
        end else if (I_CE) begin
            ack <= req && !ack;
            if (ack && I_AVS_WRITE && I_AVS_ADDRESS == REG_CFG && I_AVS_BYTEENABLE[0]) begin
                width <= I_AVS_WRITEDATA[1:0];
            end
            if (I_AVS_READ && !ack) begin
                O_AVS_READDATA <= 32'h0000_0000;
                if (I_AVS_ADDRESS == REG_CFG) begin
                    O_AVS_READDATA[1:0] <= width;
                end else if (I_AVS_ADDRESS == REG_STATUS) begin
                    O_AVS_READDATA[STAT_OPEN_LSB +: 16] <= bank_open;
                    O_AVS_READDATA[STAT_CRC_ERR_BIT] <= crc_err;
                    O_AVS_READDATA[STAT_CMD_LSB +: 3] <= last_cmd;
                    O_AVS_READDATA[STAT_BUSY_BIT] <= state != DP_IDLE;
                end else if (I_AVS_ADDRESS >= REG_MR_BASE && I_AVS_ADDRESS <= REG_MR_LAST
                             && I_AVS_ADDRESS[1:0] == 2'h0) begin
                    O_AVS_READDATA[13:0] <= mr[I_AVS_ADDRESS[4:2]];
                end
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (rst) begin
            crc_err <= 1'b0;
            last_cmd <= CMD_NOP;
        end else if (I_CE) begin
            crc_err <= crc_err_set || (crc_err && !crc_err_clr);
            if (is_cmd) begin
                last_cmd <= cmd_pins;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_act_row_open: assert property (@(posedge I_CLK) disable iff (rst)
        is_act |=> bank_open[$past(bank_idx)] && bank_row[$past(bank_idx)] == $past(row))
        else $error("activate did not open bank with row");

    a_mask_blocks_store: assert property (@(posedge I_CLK) disable iff (rst)
        (state == DP_WRITE && strobe_edge && mask_fn && !mask_pin) |-> !mem_we)
        else $error("masked beat was stored");

    a_mrs_target: assert property (@(posedge I_CLK) disable iff (rst)
        (is_cmd && cmd == CMD_MODE_SET) |=> mr[$past({bg[0], ba})] == $past(addr))
        else $error("mode register set went to wrong register");

    a_auto_prech: assert property (@(posedge I_CLK) disable iff (rst)
        (I_CE && burst_done && cur_ap && !is_act) |=> !bank_open[$past(cur_bank)])
        else $error("auto precharge did not close bank");

    a_prech_all: assert property (@(posedge I_CLK) disable iff (rst)
        (is_cmd && cmd == CMD_PRE && addr[AUTO_PRECH_BIT]) |=> bank_open == 16'h0000)
        else $error("precharge all left a bank open");

    a_chop_len: assert property (@(posedge I_CLK) disable iff (rst)
        (start_rd && !addr[CHOP_BIT]) |=> beats_left == BURST_CHOP ##1 (!$past(I_CE) || beats_left == 4'h3))
        else $error("burst chop length wrong");

    a_crc_follows: assert property (@(posedge I_CLK) disable iff (rst)
        (I_CE && state == DP_READ && beats_left == 4'h1 && crc_en) |=> state == DP_RCRC)
        else $error("crc beat not appended");

    a_read_strobe: assert property (@(posedge I_CLK) disable iff (rst)
        (I_CE && state == DP_READ) |=> O_DQS_T != $past(O_DQS_T) && !O_DQ_OE_LOW[0])
        else $error("read strobe not edge aligned");

    a_cs_ignore: assert property (@(posedge I_CLK) disable iff (rst)
        (I_CE && cs_low && !burst_done) |=> $stable(bank_open))
        else $error("command taken with chip select high");

endmodule

// file: tb/sdcad_ctrl_model.sv
`timescale 1ns/1ps

module sdcad_ctrl_model (
    input wire logic i_clk,
    output logic o_rst_low,
    output logic o_cs_low,
    output logic o_act_low,
    output logic [2:0] o_code,
    output logic [1:0] o_bg,
    output logic [1:0] o_ba,
    output logic [13:0] o_addr,
    output logic o_a17,
    output logic [7:0] o_dq,
    output logic o_dqs_t,
    output logic o_dqs_c,
    output logic o_mask_low
);
    // ----
    // Pin driver
    // ----
    initial begin
        o_rst_low = 1'b1;
        o_cs_low = 1'b1;
        o_act_low = 1'b1;
        o_code = 3'h7;
        o_bg = 2'h0;
        o_ba = 2'h0;
        o_addr = 14'h0000;
        o_a17 = 1'b0;
        o_dq = 8'h00;
        o_dqs_t = 1'b0;
        o_dqs_c = 1'b1;
        o_mask_low = 1'b1;
    end

    task cmd(input logic cs, input logic act, input logic [2:0] c, input logic [1:0] g, input logic [1:0] b,
             input logic [13:0] a);
        @(posedge i_clk);
        o_cs_low <= cs;
        o_act_low <= act;
        o_code <= c;
        o_bg <= g;
        o_ba <= b;
        o_addr <= a;
        @(posedge i_clk);
        o_cs_low <= 1'b1;
        o_act_low <= 1'b1;
        o_code <= 3'h7;
        // Released address must not keep its old value
        o_addr <= ~a;
    endtask

    task burst(input logic [7:0] base, input int m);
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clk);
            o_dq <= base + 8'(i);
            o_mask_low <= (i != m);
            o_dqs_t <= ~o_dqs_t;
            o_dqs_c <= o_dqs_t;
        end
        @(posedge i_clk);
        o_dq <= ~o_dq;
        o_mask_low <= 1'b1;
        repeat (2) @(posedge i_clk);
    endtask

    task dev_reset;
        @(posedge i_clk);
        o_rst_low <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_rst_low <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps

module testbench
    import sdcad_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] ad = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic wait_req, term, dqs_t, dqs_c, inv_flag, dqs_oe, mask_oe, rst_low, cs, act_l, a17, dqs_ti, dqs_ci, mask;
    logic ce = 1'b1;
    logic [7:0] dq_o, oe, dq_i;
    logic [2:0] code;
    logic [1:0] bg, ba;
    logic [13:0] addr;
    logic [7:0] exp_b[8];
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;

    always #12.5 clk = ~clk;

    sdcad_ctrl_model u_ctrl (.i_clk(clk), .o_rst_low(rst_low), .o_cs_low(cs), .o_act_low(act_l), .o_code(code),
        .o_bg(bg), .o_ba(ba), .o_addr(addr), .o_a17(a17), .o_dq(dq_i), .o_dqs_t(dqs_ti), .o_dqs_c(dqs_ci),
        .o_mask_low(mask));

    sdcad_top u_dut (.I_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_DEV_RESET_LOW(rst_low), .I_CHIP_SELECT_LOW(cs),
        .I_ACTIVATE_STROBE_LOW(act_l), .I_ROW_STROBE(code[2]), .I_COLUMN_STROBE(code[1]),
        .I_WRITE_ENABLE(code[0]), .I_BANK_GROUP_SELECT(bg), .I_BANK_SELECT(ba), .I_ADDR(addr), .I_ADDR17(a17),
        .I_DQ(dq_i), .O_DQ(dq_o), .O_DQ_OE_LOW(oe), .I_DQS_T(dqs_ti), .I_DQS_C(dqs_ci), .O_DQS_T(dqs_t),
        .O_DQS_C(dqs_c), .O_DQS_OE_LOW(dqs_oe), .I_WRITE_MASK_LOW(mask), .O_BUS_INVERSION_LOW(inv_flag),
        .O_MASK_PIN_OE_LOW(mask_oe), .O_TERMINATION_STROBE_EN(term), .I_AVS_ADDRESS(ad), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wait_req));

    // ----
    // Helpers
    // ----
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Gap before each access lets pin commands clear the input syncs
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        repeat (4) @(posedge clk);
        rd <= ~w;
        wr <= w;
        ad <= a;
        wd <= d;
        do @(posedge clk); while (wait_req !== 1'b0);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask

    task wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task mr(input int i, input logic [13:0] op);
        u_ctrl.cmd(1'b0, 1'b1, 3'h0, {1'b0, i[2]}, i[1:0], op);
    endtask

    task rdchk(input int n, input logic crc);
        int k;
        logic t;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (oe !== 8'h00 && k < 30);
        t = dqs_t;
        for (int i = 0; i < n; i++) begin
            if (i > 0) @(negedge clk);
            chk(32'(dq_o), 32'(exp_b[i]));
            chk({dqs_t, dqs_c, inv_flag, dqs_oe, mask_oe}, {t ^ i[0], ~(t ^ i[0]), 1'b1, 1'b0, 1'b1});
        end
        @(negedge clk);
        chk(32'(oe), crc ? 32'h0 : 32'hff);
        @(negedge clk);
        chk(32'(oe), 32'hff);
    endtask

    // ----
    // Tests
    // ----
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h00, 32'h1);
        rchk(8'h10, 32'h0);
        wreg(8'h00, 32'h2);
        rchk(8'h00, 32'h2);
        $display("test registers done");
        mr(1, 14'h0800);
        rchk(8'h24, 32'h800);
        chk(term, 1'b0);
        // Frozen clock enable must hold the bus request off
        ce <= 1'b0;
        fork
            wreg(8'h00, 32'h1);
            begin
                repeat (8) @(posedge clk);
                chk(wait_req, 1'b1);
                ce <= 1'b1;
            end
        join
        @(negedge clk);
        chk(term, 1'b1);
        // Termination strobe owns the pin until mode register one drops it
        mr(1, 14'h0000);
        mr(5, 14'h0400);
        rchk(8'h34, 32'h400);
        chk(term, 1'b0);
        $display("test mode set done");
        u_ctrl.cmd(1'b1, 1'b0, 3'h7, 2'h1, 2'h2, 14'h0);
        rchk(8'h04, 32'h0, 32'hffff);
        u_ctrl.cmd(1'b0, 1'b0, 3'h7, 2'h1, 2'h2, 14'h0);
        rchk(8'h04, 32'h40, 32'hffff);
        u_ctrl.cmd(1'b0, 1'b1, 3'h4, 2'h1, 2'h2, 14'h1000);
        u_ctrl.burst(8'ha0, 9);
        u_ctrl.cmd(1'b0, 1'b1, 3'h4, 2'h1, 2'h2, 14'h1000);
        u_ctrl.burst(8'h10, 3);
        for (int i = 0; i < 8; i++) exp_b[i] = (i == 3) ? 8'ha3 : 8'h10 + 8'(i);
        u_ctrl.cmd(1'b0, 1'b1, 3'h5, 2'h1, 2'h2, 14'h1000);
        rdchk(8, 1'b0);
        rchk(8'h04, 32'h000a0040, 32'h001fffff);
        u_ctrl.cmd(1'b0, 1'b1, 3'h5, 2'h1, 2'h2, 14'h0400);
        rdchk(4, 1'b0);
        rchk(8'h04, 32'h0, 32'hffff);
        $display("test data done");
        u_ctrl.cmd(1'b0, 1'b0, 3'h7, 2'h0, 2'h0, 14'h0);
        u_ctrl.cmd(1'b0, 1'b0, 3'h7, 2'h1, 2'h1, 14'h0);
        u_ctrl.cmd(1'b0, 1'b1, 3'h2, 2'h0, 2'h0, 14'h0);
        rchk(8'h04, 32'h20, 32'hffff);
        u_ctrl.cmd(1'b0, 1'b1, 3'h2, 2'h0, 2'h0, 14'h0400);
        rchk(8'h04, 32'h0, 32'hffff);
        mr(2, 14'h1000);
        u_ctrl.cmd(1'b0, 1'b0, 3'h7, 2'h1, 2'h2, 14'h0);
        u_ctrl.cmd(1'b0, 1'b1, 3'h5, 2'h1, 2'h2, 14'h0000);
        rdchk(4, 1'b1);
        // Chopped write: the fifth strobe edge carries a CRC byte that cannot match
        u_ctrl.cmd(1'b0, 1'b1, 3'h4, 2'h1, 2'h2, 14'h0000);
        u_ctrl.burst(8'h00, 9);
        rchk(8'h04, 32'h00010000, 32'h00010000);
        wreg(8'h04, 32'h00010000);
        rchk(8'h04, 32'h0, 32'h00010000);
        mr(4, 14'h0010);
        rchk(8'h30, 32'h10);
        @(negedge clk);
        chk({16'h0, oe, dq_o}, {16'h0, 8'hfe, 8'h01});
        u_ctrl.dev_reset();
        rchk(8'h34, 32'h0);
        $display("test banks and reset done");
        report_and_stop();
    end
endmodule
